// ===== src/sram_defs.svh
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// Beats moved by every read or write burst
`define BURST_BEATS      4
// Beat counter value of the first write data beat (one K cycle after command)
`define WR_FIRST_BEAT    3'h2
// Beat counter value of the last write data beat
`define WR_LAST_BEAT     3'h5
// Byte lane width of the data bus
`define LANE_BITS        9
// Data bits used by the eighteen-bit organisation
`define X18_BITS         18
// Full data bus width
`define DATA_BITS        36
// Depth of the read data FIFO in words
`define FIFO_WORDS       16
// Clock period in ns at 250 MHz
`define MCLK_PERIOD_NS   4

`endif

// ===== src/sram_pkg.sv
package sram_pkg;

    // Write side sequencer
    typedef enum logic [0:0] {
        WR_IDLE,
        WR_RUN
    } wr_state_t;

    // Read side sequencer
    typedef enum logic [0:0] {
        RD_IDLE,
        RD_RUN
    } rd_state_t;

endpackage : sram_pkg

// ===== src/beat_fifo.sv
`timescale 1ns/1ps

module beat_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,      // Core clock
    input  wire logic             resetn,    // Synchronous reset, active low
    input  wire logic [WIDTH-1:0] in_data,   // Word to store
    input  wire logic             in_valid,  // Store request
    output logic                  in_ready,  // Room for one more word
    output logic      [WIDTH-1:0] out_data,  // Oldest word
    output logic                  out_valid, // Oldest word present
    input  wire logic             out_ready  // Drain request
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [PW:0]      count_reg, count_next;
    logic             push;
    logic             pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (count_reg != (PW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and storage update
    always_comb begin
        mem_next    = mem_reg;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next  = count_reg;
        if (push) begin
            mem_next[wr_ptr_reg] = in_data;
            wr_ptr_next          = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Storage is not cleared; only the pointers and the count matter after reset
    always_ff @(posedge mclk) begin
        mem_reg <= mem_next;
        if (!resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

endmodule : beat_fifo

// ===== src/sync_sram_command_pins.sv
`timescale 1ns/1ps
`include "sram_defs.svh"

// Overview of operation
// - Write select low at K edge starts write
// - Read select low at K edge starts read
// - Masked byte lanes keep old memory contents
// - Lane masks sampled with their own beat
// - Output bus moves only for reads
// - Eighteen-bit organisation leaves upper outputs idle
// - Both output clocks high: align to K
// - Address ignored while device is deselected
module sync_sram_command_pins #(
    parameter int ADDR_W  = 4,                 // Burst address width
    parameter bit ORG_X18 = 1'b0               // Eighteen-bit organisation
) (
    input  wire logic                   mclk,             // Core clock, beat rate
    input  wire logic                   resetn,           // Synchronous reset, active low
    input  wire logic                   read_sel_n,       // Read select pin
    input  wire logic                   write_sel_n,      // Write select pin
    input  wire logic [ADDR_W-1:0]      word_location_in, // Burst address pins
    input  wire logic [`DATA_BITS-1:0]  write_data_in,    // Write data beat pins
    input  wire logic [`DATA_BITS/`LANE_BITS-1:0] lane_mask_n, // Byte lane masks
    input  wire logic                   out_clk_hi,       // Output clock pin, true
    input  wire logic                   out_clk_hi_n,     // Output clock pin, complement
    input  wire logic                   fetch_ready_in,   // Host takes read beats
    output logic                        k_phase_out,      // High on K# beat slots
    output logic [`DATA_BITS-1:0]       fetch_data_out,   // Read data beat
    output logic                        fetch_valid_out   // Read beat present
);
    localparam int LANES  = `DATA_BITS / `LANE_BITS;
    localparam int WORDS  = (2 ** ADDR_W) * `BURST_BEATS;
    localparam int WIDX_W = ADDR_W + 2;
    localparam logic [`DATA_BITS-1:0] USED_MASK =
        ORG_X18 ? `DATA_BITS'((1 << `X18_BITS) - 1) : {`DATA_BITS{1'b1}};

    // Two-flop pin synchronisers; stage one feeds stage two only
    logic                  rsel_s1_reg, rsel_s2_reg;
    logic                  wsel_s1_reg, wsel_s2_reg;
    logic [ADDR_W-1:0]     loc_s1_reg, loc_s2_reg;
    logic [`DATA_BITS-1:0] din_s1_reg, din_s2_reg;
    logic [LANES-1:0]      mask_s1_reg, mask_s2_reg;
    logic                  ch_s1_reg, ch_s2_reg;
    logic                  chn_s1_reg, chn_s2_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rsel_s1_reg <= 1'b1;
            rsel_s2_reg <= 1'b1;
            wsel_s1_reg <= 1'b1;
            wsel_s2_reg <= 1'b1;
            loc_s1_reg  <= '0;
            loc_s2_reg  <= '0;
            din_s1_reg  <= '0;
            din_s2_reg  <= '0;
            mask_s1_reg <= '1;
            mask_s2_reg <= '1;
            ch_s1_reg   <= 1'b0;
            ch_s2_reg   <= 1'b0;
            chn_s1_reg  <= 1'b0;
            chn_s2_reg  <= 1'b0;
        end else begin
            rsel_s1_reg <= read_sel_n;
            rsel_s2_reg <= rsel_s1_reg;
            wsel_s1_reg <= write_sel_n;
            wsel_s2_reg <= wsel_s1_reg;
            loc_s1_reg  <= word_location_in;
            loc_s2_reg  <= loc_s1_reg;
            din_s1_reg  <= write_data_in;
            din_s2_reg  <= din_s1_reg;
            mask_s1_reg <= lane_mask_n;
            mask_s2_reg <= mask_s1_reg;
            ch_s1_reg   <= out_clk_hi;
            ch_s2_reg   <= ch_s1_reg;
            chn_s1_reg  <= out_clk_hi_n;
            chn_s2_reg  <= chn_s1_reg;
        end
    end

    // K phase: 0 is the rising K slot, 1 the rising K# slot
    logic k_phase_reg, k_phase_next;
    assign k_phase_next = ~k_phase_reg;
    assign k_phase_out  = k_phase_reg;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            k_phase_reg <= 1'b0;
        end else begin
            k_phase_reg <= k_phase_next;
        end
    end

    // Command decode; a deselected slot never touches the address
    sram_pkg::wr_state_t wr_state_reg, wr_state_next;
    sram_pkg::rd_state_t rd_state_reg, rd_state_next;
    logic                wr_take;
    logic                rd_take;
    assign wr_take = !k_phase_reg && !wsel_s2_reg && (wr_state_reg == sram_pkg::WR_IDLE);
    assign rd_take = !k_phase_reg && !rsel_s2_reg && (rd_state_reg == sram_pkg::RD_IDLE);

    // Write sequencer: beats land one K cycle after the command
    logic [2:0]        wr_cnt_reg, wr_cnt_next;
    logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
    logic              wr_beat;
    logic [1:0]        wr_beat_idx;
    assign wr_beat     = (wr_state_reg == sram_pkg::WR_RUN) && (wr_cnt_reg >= `WR_FIRST_BEAT);
    assign wr_beat_idx = 2'(wr_cnt_reg - `WR_FIRST_BEAT);

    always_comb begin
        wr_state_next = wr_state_reg;
        wr_cnt_next   = wr_cnt_reg;
        wr_addr_next  = wr_addr_reg;
        case (wr_state_reg)
            sram_pkg::WR_IDLE: begin
                if (wr_take) begin
                    wr_state_next = sram_pkg::WR_RUN;
                    wr_cnt_next   = 3'h1;
                    wr_addr_next  = loc_s2_reg;
                end
            end
            sram_pkg::WR_RUN: begin
                if (wr_cnt_reg == `WR_LAST_BEAT) begin
                    wr_state_next = sram_pkg::WR_IDLE;
                    wr_cnt_next   = 3'h0;
                end else begin
                    wr_cnt_next   = wr_cnt_reg + 3'h1;
                end
            end
            default: begin
                wr_state_next = sram_pkg::WR_IDLE;
                wr_cnt_next   = 3'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wr_state_reg <= sram_pkg::WR_IDLE;
            wr_cnt_reg   <= 3'h0;
            wr_addr_reg  <= '0;
        end else begin
            wr_state_reg <= wr_state_next;
            wr_cnt_reg   <= wr_cnt_next;
            wr_addr_reg  <= wr_addr_next;
        end
    end

    // Flip-flop storage, one word per beat of each burst address
    logic [`DATA_BITS-1:0] mem_reg [WORDS];
    logic [`DATA_BITS-1:0] mem_next [WORDS];
    logic [WIDX_W-1:0]     wr_idx;
    logic [`DATA_BITS-1:0] merged_word;
    assign wr_idx = {wr_addr_reg, wr_beat_idx};

    // Per-lane merge; the mask of this very beat picks old or new
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        assign merged_word[l*`LANE_BITS +: `LANE_BITS] = mask_s2_reg[l] ?
            mem_reg[wr_idx][l*`LANE_BITS +: `LANE_BITS] :
            din_s2_reg[l*`LANE_BITS +: `LANE_BITS];
    end

    always_comb begin
        mem_next = mem_reg;
        if (wr_beat) begin
            mem_next[wr_idx] = merged_word & USED_MASK;
        end
    end

    // Contents are undefined until written, as in a real array
    always_ff @(posedge mclk) begin
        mem_reg <= mem_next;
    end

    // Read sequencer: pushes four beats, stalls on a full FIFO
    logic [ADDR_W-1:0]     rd_addr_reg, rd_addr_next;
    logic [1:0]            rd_beat_reg, rd_beat_next;
    logic                  push;
    logic                  push_ready;
    assign push = (rd_state_reg == sram_pkg::RD_RUN) && push_ready;

    always_comb begin
        rd_state_next = rd_state_reg;
        rd_addr_next  = rd_addr_reg;
        rd_beat_next  = rd_beat_reg;
        case (rd_state_reg)
            sram_pkg::RD_IDLE: begin
                if (rd_take) begin
                    rd_state_next = sram_pkg::RD_RUN;
                    rd_addr_next  = loc_s2_reg;
                    rd_beat_next  = 2'h0;
                end
            end
            sram_pkg::RD_RUN: begin
                if (push) begin
                    rd_beat_next = rd_beat_reg + 2'h1;
                    if (rd_beat_reg == 2'(`BURST_BEATS - 1)) begin
                        rd_state_next = sram_pkg::RD_IDLE;
                    end
                end
            end
            default: begin
                rd_state_next = sram_pkg::RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rd_state_reg <= sram_pkg::RD_IDLE;
            rd_addr_reg  <= '0;
            rd_beat_reg  <= 2'h0;
        end else begin
            rd_state_reg <= rd_state_next;
            rd_addr_reg  <= rd_addr_next;
            rd_beat_reg  <= rd_beat_next;
        end
    end

    // Read beats queue here so a slow host cannot drop data
    logic [`DATA_BITS-1:0] fifo_data;
    logic                  fifo_valid;
    logic                  pop;

    beat_fifo #(
        .WIDTH (`DATA_BITS),
        .DEPTH (`FIFO_WORDS)
    ) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_data   (mem_reg[{rd_addr_reg, rd_beat_reg}]),
        .in_valid  (rd_state_reg == sram_pkg::RD_RUN),
        .in_ready  (push_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop)
    );

    // Output stage; with both output clocks tied high beats follow K parity
    logic                  clk_pair_tied;
    logic                  out_par_reg, out_par_next;
    logic [`DATA_BITS-1:0] q_reg, q_next;
    logic                  qv_reg, qv_next;
    assign clk_pair_tied = ch_s2_reg && chn_s2_reg;
    assign pop = fifo_valid && fetch_ready_in &&
                 (!clk_pair_tied || (out_par_reg == k_phase_reg));

    always_comb begin
        out_par_next = pop ? ~out_par_reg : out_par_reg;
        q_next       = pop ? (fifo_data & USED_MASK) : '0;
        qv_next      = pop;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            out_par_reg <= 1'b0;
            q_reg       <= '0;
            qv_reg      <= 1'b0;
        end else begin
            out_par_reg <= out_par_next;
            q_reg       <= q_next;
            qv_reg      <= qv_next;
        end
    end

    assign fetch_data_out  = q_reg;
    assign fetch_valid_out = qv_reg;

    // Checks on the sequencing above
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic [`LANE_BITS-1:0] lane0_old;
    assign lane0_old = mem_reg[wr_idx][`LANE_BITS-1:0];

    sequence s_write_beats;
        ##2 wr_beat [*4] ##1 !wr_beat;
    endsequence

    a_write_accept: assert property (wr_take |=> wr_addr_reg == $past(loc_s2_reg))
        else $error("write address not captured");
    a_read_accept: assert property (rd_take |=> rd_state_reg == sram_pkg::RD_RUN
        && rd_addr_reg == $past(loc_s2_reg) && rd_beat_reg == 2'h0)
        else $error("read address not captured");
    a_mask_keep: assert property (wr_beat && mask_s2_reg[0]
        |=> mem_reg[$past(wr_idx)][`LANE_BITS-1:0] == $past(lane0_old))
        else $error("masked lane was written");
    a_mask_same_beat: assert property (wr_beat && !mask_s2_reg[0]
        |=> mem_reg[$past(wr_idx)][`LANE_BITS-1:0] == $past(din_s2_reg[`LANE_BITS-1:0]))
        else $error("unmasked lane not written with its beat");
    a_read_only_out: assert property (fetch_valid_out |-> $past(fifo_valid))
        else $error("output beat without read data");
    a_idle_out_zero: assert property (!fetch_valid_out |-> fetch_data_out == '0)
        else $error("output bus moved without a read");
    a_upper_idle: assert property (ORG_X18 |-> (fetch_data_out & ~USED_MASK) == '0)
        else $error("upper output bits carry data");
    a_pair_align: assert property ($past(clk_pair_tied) && fetch_valid_out
        |-> k_phase_reg != $past(out_par_reg))
        else $error("output beat off K parity");
    a_deselect_ignore: assert property (rsel_s2_reg && wsel_s2_reg
        |=> $stable(wr_addr_reg) && $stable(rd_addr_reg))
        else $error("address taken while deselected");
    a_write_burst: assert property (wr_take |-> s_write_beats)
        else $error("write burst not four beats one K later");

endmodule : sync_sram_command_pins

// ===== tb/host_ctrl_model.sv
`timescale 1ns/1ps
`include "sram_defs.svh"

// Host memory controller; every pin change lands on a falling edge
module host_ctrl_model #(
    parameter int ADDR_W = 4                      // Burst address width
) (
    input  wire logic                        mclk,             // Core clock
    input  wire logic                        k_phase_out,      // Slot parity from device
    output logic                             read_sel_n,       // Read select
    output logic                             write_sel_n,      // Write select
    output logic [ADDR_W-1:0]                word_location_in, // Burst address
    output logic [`DATA_BITS-1:0]            write_data_in,    // Write beat data
    output logic [`DATA_BITS/`LANE_BITS-1:0] lane_mask_n,      // Lane masks
    output logic                             align_err         // No K slot found
);
    // Idle pins until the bench asks for traffic
    initial begin
        read_sel_n       = 1'b1;
        write_sel_n      = 1'b1;
        word_location_in = '0;
        write_data_in    = '0;
        lane_mask_n      = 4'hF;
        align_err        = 1'b0;
    end

    // Commands only go out in K slots, K# slots are ignored
    task automatic slot_align();
        for (int i = 0; i < 3 && k_phase_out !== 1'b0; i++) @(negedge mclk);
        if (k_phase_out !== 1'b0) align_err = 1'b1;
    endtask : slot_align

    // Command slot, a one-slot K# gap, then four beats each with its own masks
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [4*`DATA_BITS-1:0] d,
                      input logic [15:0] m);
        slot_align();
        write_sel_n      = 1'b0;
        word_location_in = a;
        @(negedge mclk);
        write_sel_n      = 1'b1;
        word_location_in = ~a; // Released address never repeats its last value
        @(negedge mclk);
        for (int b = 0; b < 4; b++) begin
            write_data_in = d[`DATA_BITS*b +: `DATA_BITS];
            lane_mask_n   = m[4*b +: 4];
            @(negedge mclk);
        end
        write_data_in = ~write_data_in;
        lane_mask_n   = ~lane_mask_n;
    endtask : wr

    // Read command for one burst
    task automatic rd(input logic [ADDR_W-1:0] a);
        slot_align();
        read_sel_n       = 1'b0;
        word_location_in = a;
        @(negedge mclk);
        read_sel_n       = 1'b1;
        word_location_in = ~a;
    endtask : rd

    // Deselected cycles with the address wandering
    task automatic idle(input int n);
        repeat (n) begin
            word_location_in = word_location_in + 1'b1;
            @(negedge mclk);
        end
    endtask : idle
endmodule : host_ctrl_model

// ===== tb/tb_sync_sram_command_pins.sv
`timescale 1ns/1ps
`include "sram_defs.svh"

module tb_sync_sram_command_pins;
    localparam int AW = 4;
    logic          mclk = 1'b0;
    logic          resetn;
    logic          fetch_ready_in;
    logic          oc_hi;
    logic          oc_hi_n;
    logic          rs_n;
    logic          ws_n;
    logic          align_err;
    logic [AW-1:0] addr;
    logic [35:0]   wdata;
    logic [3:0]    mask_n;
    logic          k_phase_out;
    logic          fetch_valid_out;
    logic [35:0]   fetch_data_out;
    logic          v18;
    logic [35:0]   q18;
    logic [35:0]   exp_mem [64];
    logic [35:0]   exp_q [$];
    int            fail_count = 0;
    int            num_checks = 0;
    int            seen_valid = 0;
    bit            tied = 1'b0;

    always #(`MCLK_PERIOD_NS / 2.0) mclk = ~mclk;

    host_ctrl_model #(.ADDR_W(AW)) host (.mclk(mclk), .k_phase_out(k_phase_out),
        .read_sel_n(rs_n), .write_sel_n(ws_n), .word_location_in(addr),
        .write_data_in(wdata), .lane_mask_n(mask_n), .align_err(align_err));

    sync_sram_command_pins #(.ADDR_W(AW), .ORG_X18(1'b0)) dut (.mclk(mclk),
        .resetn(resetn), .read_sel_n(rs_n), .write_sel_n(ws_n), .word_location_in(addr),
        .write_data_in(wdata), .lane_mask_n(mask_n), .out_clk_hi(oc_hi),
        .out_clk_hi_n(oc_hi_n), .fetch_ready_in(fetch_ready_in), .k_phase_out(k_phase_out),
        .fetch_data_out(fetch_data_out), .fetch_valid_out(fetch_valid_out));

    // Narrow organisation shares every input pin with the wide one
    sync_sram_command_pins #(.ADDR_W(AW), .ORG_X18(1'b1)) dut_x18 (.mclk(mclk),
        .resetn(resetn), .read_sel_n(rs_n), .write_sel_n(ws_n), .word_location_in(addr),
        .write_data_in(wdata), .lane_mask_n(mask_n), .out_clk_hi(oc_hi),
        .out_clk_hi_n(oc_hi_n), .fetch_ready_in(fetch_ready_in), .k_phase_out(),
        .fetch_data_out(q18), .fetch_valid_out(v18));

    // Every read beat seen on the wide device
    always @(negedge mclk) if (fetch_valid_out === 1'b1) seen_valid++;

    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            fail_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    // Expected memory follows only unmasked lanes of each beat
    task automatic write_word(input logic [AW-1:0] a, input logic [143:0] d,
                              input logic [15:0] m);
        for (int b = 0; b < 4; b++)
            for (int l = 0; l < 4; l++)
                if (!m[4*b+l]) exp_mem[{a, 2'(b)}][9*l +: 9] = d[36*b+9*l +: 9];
        host.wr(a, d, m);
    endtask : write_word

    task automatic write_pat(input logic [AW-1:0] a);
        logic [143:0] d;
        for (int b = 0; b < 4; b++) d[36*b +: 36] = {28'hC3A596F, a, 2'(b), 2'h1};
        write_word(a, d, 16'h0000);
    endtask : write_pat

    task automatic read_burst(input logic [AW-1:0] a);
        for (int b = 0; b < 4; b++) exp_q.push_back(exp_mem[{a, 2'(b)}]);
        host.rd(a);
    endtask : read_burst

    // Beats come out in burst order; upper half idle on the narrow device
    task automatic collect(input int n);
        int got;
        logic [35:0] e;
        got = 0;
        for (int i = 0; i < 300 && got < n; i++) begin
            @(negedge mclk);
            if (fetch_valid_out === 1'b1) begin
                e = exp_q.pop_front();
                check(fetch_data_out === e, "read beat data wrong");
                check(v18 === 1'b1 && q18 === {18'h0, e[17:0]}, "narrow beat wrong");
                if (tied) check(k_phase_out === ~got[0], "beat off K alignment");
                got++;
            end
        end
        if (got < n || align_err !== 1'b0) begin
            check(1'b0, "read beats missing");
            tally_and_finish();
        end
    endtask : collect

    task automatic s_basic();
        write_word(4'h3, 144'h123456789_ABCDEF012_3456789AB_CDEF01234, 16'h0000);
        repeat (2) @(negedge mclk);
        read_burst(4'h3);
        collect(4);
    endtask : s_basic

    // Each beat carries a different mask, so a mask on the wrong beat shows up
    task automatic s_masks();
        write_word(4'h3, 144'hFEDCBA987_0F0F0F0F0_55555AAAA_111122223, 16'h0AE5);
        repeat (2) @(negedge mclk);
        read_burst(4'h3);
        collect(4);
    endtask : s_masks

    // Writes and deselected cycles leave the read bus silent and memory alone
    task automatic s_quiet();
        int v0;
        // Let the beat counter settle on the last beat of the previous burst
        @(negedge mclk);
        v0 = seen_valid;
        write_pat(4'h5);
        host.idle(16);
        check(seen_valid == v0, "read beat after write or deselect");
        // A read is busy until its beats are pushed, so drain before the next one
        read_burst(4'h3);
        collect(4);
        read_burst(4'h5);
        collect(4);
    endtask : s_quiet

    // Host stalls until the beat buffer is full, then drains it all
    task automatic s_fill();
        int v0;
        for (int r = 0; r < 5; r++) write_pat(AW'(r));
        fetch_ready_in = 1'b0;
        v0 = seen_valid;
        for (int r = 0; r < 5; r++) begin
            read_burst(AW'(r));
            repeat (5) @(negedge mclk);
        end
        repeat (20) @(negedge mclk);
        check(seen_valid == v0, "beat sent while stalled");
        fetch_ready_in = 1'b1;
        collect(20);
    endtask : s_fill

    // Output clocks tied high; release the stall on a K slot as well
    task automatic s_tied();
        oc_hi = 1'b1;
        tied  = 1'b1;
        repeat (4) @(negedge mclk);
        read_burst(4'h3);
        collect(4);
        fetch_ready_in = 1'b0;
        read_burst(4'h5);
        repeat (9) @(negedge mclk);
        fetch_ready_in = 1'b1;
        collect(4);
        oc_hi = 1'b0;
        tied  = 1'b0;
    endtask : s_tied

    initial begin
        resetn         = 1'b0;
        fetch_ready_in = 1'b1;
        oc_hi          = 1'b0;
        oc_hi_n        = 1'b1;
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        s_basic();
        s_masks();
        s_quiet();
        s_fill();
        s_tied();
        repeat (10) @(negedge mclk);
        check(exp_q.size() == 0 && align_err === 1'b0, "unfinished traffic");
        tally_and_finish();
    end
endmodule : tb_sync_sram_command_pins
